// ### logic/iocn_defines.vh
// Constants for the pin change notifier and output remapper
//
// Function
// - Style clear: low enable flags any mismatch
// - Style set, low only: rising edges
// - Style set, high only: falling edges
// - Style set, both enables: both edges
// - Status bit shows change since read
// - Event flag set on selected edge
// - Event flag sticky until software clears
// - Interrupt only from pins set as input in direction register, even pin 0 driven by fixed peripheral
// - Peripheral inputs and outputs mapped independently
// - Lock protects mapping against spurious writes
// - Remappable peripheral unconnected until assigned
// - Fixed peripheral always on its pin
// - First map register: b13-8 pin b
// - Second map register: b13-8 pin d
// - Bits 15-14, 7-6 read zero
// - Mapped outputs are internal virtual ports
// - Nothing detected until control bit 15
// - Edge style select at bit 11
// - Detection never depends on sleep state
`ifndef IOCN_DEFINES_VH
`define IOCN_DEFINES_VH

// ******************************
// Widths
// ******************************
`define IOCN_NPINS 16
`define IOCN_AW 8
`define IOCN_DW 16
`define IOCN_NFUNC 64

// ******************************
// Register offsets
// ******************************
`define IOCN_ADDR_CTRL 8'h00
`define IOCN_ADDR_DIR 8'h04
`define IOCN_ADDR_PORT 8'h08
`define IOCN_ADDR_ENLO 8'h0c
`define IOCN_ADDR_ENHI 8'h10
`define IOCN_ADDR_STAT 8'h14
`define IOCN_ADDR_FLAG 8'h18
`define IOCN_ADDR_MAP_AB 8'h1c
`define IOCN_ADDR_MAP_CD 8'h20
`define IOCN_ADDR_LOCK 8'h24
`define IOCN_ADDR_INMAP 8'h28
`define IOCN_ADDR_LAT 8'h2c

// ******************************
// Fields
// ******************************
`define IOCN_CTRL_ON 15
`define IOCN_CTRL_STYLE 11
`define IOCN_MAP_HI_MSB 13
`define IOCN_MAP_HI_LSB 8
`define IOCN_MAP_LO_MSB 5
`define IOCN_MAP_LO_LSB 0
`define IOCN_MAP_MASK 16'h3f3f
`define IOCN_INMAP_MASK 16'h1f1f
`define IOCN_LOCK_BIT 0
`define IOCN_UNLOCK_KEY 16'h5a3c

// ******************************
// Reset values
// ******************************
`define IOCN_RST_DIR 16'hffff
`define IOCN_RST_ZERO 16'h0000
`define IOCN_FUNC_NONE 6'h00
`define IOCN_INSEL_NONE 5'h00
`define IOCN_INSEL_VIRT 5'h11

`endif

// ### logic/iocn_detect.v
// Pin synchroniser and change/edge detector for one port
`timescale 1ns/10ps
`default_nettype none
`include "iocn_defines.vh"

module iocn_detect (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [`IOCN_NPINS-1:0] i_pin,
  input wire [`IOCN_NPINS-1:0] i_ref,
  input wire i_on,
  input wire i_style,
  input wire [`IOCN_NPINS-1:0] i_en_lo,
  input wire [`IOCN_NPINS-1:0] i_en_hi,
  output wire [`IOCN_NPINS-1:0] o_cur,
  output wire [`IOCN_NPINS-1:0] o_chg,
  output reg [`IOCN_NPINS-1:0] o_hit
);

  reg [`IOCN_NPINS-1:0] meta_reg;
  reg [`IOCN_NPINS-1:0] sync_reg;
  reg [`IOCN_NPINS-1:0] prev_reg;
  wire [`IOCN_NPINS-1:0] rise;
  wire [`IOCN_NPINS-1:0] fall;
  wire [`IOCN_NPINS-1:0] mism;

  // ******************************
  // Two-stage pin synchroniser and history
  // ******************************
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= `IOCN_RST_ZERO;
      sync_reg <= `IOCN_RST_ZERO;
      prev_reg <= `IOCN_RST_ZERO;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge and mismatch terms from synchronised level
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
  assign mism = sync_reg ^ i_ref;
  assign o_cur = sync_reg;
  assign o_chg = i_on ? (rise | fall) : `IOCN_RST_ZERO;

  // Event select from style and the two enables, no sleep gating
  always @* begin
    if (!i_on) begin
      o_hit = `IOCN_RST_ZERO;
    end else if (!i_style) begin
      o_hit = i_en_lo & mism;
    end else begin
      o_hit = (i_en_lo & rise) | (i_en_hi & fall);
    end
  end

endmodule
`default_nettype wire

// ### logic/iocn_top.v
// Port change notifier with protected output and input remapping
`timescale 1ns/10ps
`default_nettype none
`include "iocn_defines.vh"

module iocn_top (
  input wire i_clk_sys,
  input wire i_rst,
  // Register port
  input wire [`IOCN_AW-1:0] i_addr,
  input wire [`IOCN_DW-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`IOCN_DW-1:0] o_rdata,
  // Physical port pins
  input wire [`IOCN_NPINS-1:0] i_pin,
  output reg [`IOCN_NPINS-1:0] o_pin_out,
  output reg [`IOCN_NPINS-1:0] o_pin_oe,
  // Peripheral side
  input wire [`IOCN_NFUNC-1:0] i_periph_out,
  input wire i_fixed_en,
  input wire i_fixed_out,
  output reg [1:0] o_periph_in,
  output reg [3:0] o_virt_pin,
  // Change notification request and map lock state
  output reg o_cn_irq,
  output reg o_map_locked
);

  // ******************************
  // Register state
  // ******************************
  reg ctrl_on_reg;
  reg ctrl_style_reg;
  reg [`IOCN_NPINS-1:0] dir_reg;
  reg [`IOCN_NPINS-1:0] en_lo_reg;
  reg [`IOCN_NPINS-1:0] en_hi_reg;
  reg [`IOCN_NPINS-1:0] stat_reg;
  reg [`IOCN_NPINS-1:0] flag_reg;
  reg [`IOCN_NPINS-1:0] ref_reg;
  reg [`IOCN_NPINS-1:0] lat_reg;
  reg [`IOCN_DW-1:0] map_ab_reg;
  reg [`IOCN_DW-1:0] map_cd_reg;
  reg [`IOCN_DW-1:0] inmap_reg;
  reg lock_reg;

  reg [`IOCN_NPINS-1:0] stat_next;
  reg [`IOCN_NPINS-1:0] flag_next;
  reg [`IOCN_DW-1:0] rdata_next;
  reg [3:0] virt_next;
  reg [1:0] pin_in_next;
  reg [`IOCN_NPINS-1:0] pin_out_next;

  wire [`IOCN_NPINS-1:0] cur_pin;
  wire [`IOCN_NPINS-1:0] chg_pin;
  wire [`IOCN_NPINS-1:0] hit_pin;
  wire wr_ctrl;
  wire wr_dir;
  wire wr_enlo;
  wire wr_enhi;
  wire wr_flag;
  wire wr_map_ab;
  wire wr_map_cd;
  wire wr_lock;
  wire wr_inmap;
  wire wr_lat;
  wire rd_port;
  wire map_open;

  // ******************************
  // Functions
  // ******************************

  // Picks the peripheral output chosen by a function number
  function func_pick;
    input [5:0] num;
    input [`IOCN_NFUNC-1:0] src;
    begin
      if (num == `IOCN_FUNC_NONE) begin
        func_pick = 1'b0;
      end else begin
        func_pick = src[num];
      end
    end
  endfunction

  // Picks a remappable source for a peripheral input
  function in_pick;
    input [4:0] sel;
    input [`IOCN_NPINS-1:0] pins;
    input [3:0] virt;
    reg [4:0] idx;
    begin
      idx = sel - 5'h01;
      if (sel == `IOCN_INSEL_NONE) begin
        in_pick = 1'b0;
      end else if (sel < `IOCN_INSEL_VIRT) begin
        in_pick = pins[idx[3:0]];
      end else if (sel < `IOCN_INSEL_VIRT + 5'h04) begin
        in_pick = virt[sel[1:0] - 2'h1];
      end else begin
        in_pick = 1'b0;
      end
    end
  endfunction

  // Address match for one register with a strobe
  function hit_addr;
    input strobe;
    input [`IOCN_AW-1:0] addr;
    input [`IOCN_AW-1:0] want;
    begin
      hit_addr = strobe && (addr == want);
    end
  endfunction

  // ******************************
  // Detector
  // ******************************
  iocn_detect u_detect (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_pin),
    .i_ref(ref_reg),
    .i_on(ctrl_on_reg),
    .i_style(ctrl_style_reg),
    .i_en_lo(en_lo_reg),
    .i_en_hi(en_hi_reg),
    .o_cur(cur_pin),
    .o_chg(chg_pin),
    .o_hit(hit_pin)
  );

  // ******************************
  // Write decode
  // ******************************
  assign wr_ctrl = hit_addr(i_wr, i_addr, `IOCN_ADDR_CTRL);
  assign wr_dir = hit_addr(i_wr, i_addr, `IOCN_ADDR_DIR);
  assign wr_enlo = hit_addr(i_wr, i_addr, `IOCN_ADDR_ENLO);
  assign wr_enhi = hit_addr(i_wr, i_addr, `IOCN_ADDR_ENHI);
  assign wr_flag = hit_addr(i_wr, i_addr, `IOCN_ADDR_FLAG);
  assign wr_map_ab = hit_addr(i_wr, i_addr, `IOCN_ADDR_MAP_AB);
  assign wr_map_cd = hit_addr(i_wr, i_addr, `IOCN_ADDR_MAP_CD);
  assign wr_lock = hit_addr(i_wr, i_addr, `IOCN_ADDR_LOCK);
  assign wr_inmap = hit_addr(i_wr, i_addr, `IOCN_ADDR_INMAP);
  assign wr_lat = hit_addr(i_wr, i_addr, `IOCN_ADDR_LAT);
  assign rd_port = hit_addr(i_rd, i_addr, `IOCN_ADDR_PORT);
  assign map_open = !lock_reg;

  // ******************************
  // Status and flag next values
  // ******************************

  // Set terms win over software clears
  always @* begin
    stat_next = stat_reg;
    if (rd_port) begin
      stat_next = `IOCN_RST_ZERO;
    end
    stat_next = stat_next | chg_pin;
    flag_next = flag_reg;
    if (wr_flag) begin
      flag_next = flag_reg & ~i_wdata;
    end
    flag_next = flag_next | hit_pin;
  end

  // ******************************
  // Control registers
  // ******************************
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_on_reg <= 1'b0;
      ctrl_style_reg <= 1'b0;
      dir_reg <= `IOCN_RST_DIR;
      en_lo_reg <= `IOCN_RST_ZERO;
      en_hi_reg <= `IOCN_RST_ZERO;
      lat_reg <= `IOCN_RST_ZERO;
    end else begin
      if (wr_ctrl) begin
        ctrl_on_reg <= i_wdata[`IOCN_CTRL_ON];
        ctrl_style_reg <= i_wdata[`IOCN_CTRL_STYLE];
      end
      if (wr_dir) begin
        dir_reg <= i_wdata;
      end
      if (wr_enlo) begin
        en_lo_reg <= i_wdata;
      end
      if (wr_enhi) begin
        en_hi_reg <= i_wdata;
      end
      if (wr_lat) begin
        lat_reg <= i_wdata;
      end
    end
  end

  // ******************************
  // Change state
  // ******************************

  // Reference level captured on every port read
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= `IOCN_RST_ZERO;
      flag_reg <= `IOCN_RST_ZERO;
      ref_reg <= `IOCN_RST_ZERO;
    end else begin
      stat_reg <= stat_next;
      flag_reg <= flag_next;
      if (rd_port) begin
        ref_reg <= cur_pin;
      end
    end
  end

  // ******************************
  // Mapping registers and lock
  // ******************************

  // Map writes ignored while locked; reserved bits never stored
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      map_ab_reg <= `IOCN_RST_ZERO;
      map_cd_reg <= `IOCN_RST_ZERO;
      inmap_reg <= `IOCN_RST_ZERO;
      lock_reg <= 1'b0;
    end else begin
      if (wr_map_ab && map_open) begin
        map_ab_reg <= i_wdata & `IOCN_MAP_MASK;
      end
      if (wr_map_cd && map_open) begin
        map_cd_reg <= i_wdata & `IOCN_MAP_MASK;
      end
      if (wr_inmap && map_open) begin
        inmap_reg <= i_wdata & `IOCN_INMAP_MASK;
      end
      if (wr_lock) begin
        if (i_wdata == `IOCN_UNLOCK_KEY) begin
          lock_reg <= 1'b0;
        end else if (i_wdata[`IOCN_LOCK_BIT]) begin
          lock_reg <= 1'b1;
        end
      end
    end
  end

  // ******************************
  // Routing
  // ******************************

  // Virtual ports carry only the selected peripheral outputs
  always @* begin
    virt_next[0] = func_pick(map_ab_reg[`IOCN_MAP_LO_MSB:`IOCN_MAP_LO_LSB], i_periph_out);
    virt_next[1] = func_pick(map_ab_reg[`IOCN_MAP_HI_MSB:`IOCN_MAP_HI_LSB], i_periph_out);
    virt_next[2] = func_pick(map_cd_reg[`IOCN_MAP_LO_MSB:`IOCN_MAP_LO_LSB], i_periph_out);
    virt_next[3] = func_pick(map_cd_reg[`IOCN_MAP_HI_MSB:`IOCN_MAP_HI_LSB], i_periph_out);
  end

  // Peripheral inputs each from their own selected source
  always @* begin
    pin_in_next[0] = in_pick(inmap_reg[4:0], cur_pin, o_virt_pin);
    pin_in_next[1] = in_pick(inmap_reg[12:8], cur_pin, o_virt_pin);
  end

  // Fixed peripheral owns pin 0 whenever it is active
  always @* begin
    pin_out_next = lat_reg;
    if (i_fixed_en) begin
      pin_out_next[0] = i_fixed_out;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_virt_pin <= 4'h0;
      o_periph_in <= 2'h0;
      o_pin_out <= `IOCN_RST_ZERO;
      o_pin_oe <= `IOCN_RST_ZERO;
      o_cn_irq <= 1'b0;
      o_map_locked <= 1'b0;
    end else begin
      o_virt_pin <= virt_next;
      o_periph_in <= pin_in_next;
      o_pin_out <= pin_out_next;
      o_pin_oe <= ~dir_reg | {{(`IOCN_NPINS-1){1'b0}}, i_fixed_en};
      o_cn_irq <= ctrl_on_reg && |(flag_reg & dir_reg);
      o_map_locked <= lock_reg;
    end
  end

  // ******************************
  // Read path
  // ******************************

  // If-chain decode; unmapped addresses read zero
  always @* begin
    rdata_next = `IOCN_RST_ZERO;
    if (i_rd) begin
      if (i_addr == `IOCN_ADDR_CTRL) begin
        rdata_next[`IOCN_CTRL_ON] = ctrl_on_reg;
        rdata_next[`IOCN_CTRL_STYLE] = ctrl_style_reg;
      end else if (i_addr == `IOCN_ADDR_DIR) begin
        rdata_next = dir_reg;
      end else if (i_addr == `IOCN_ADDR_PORT) begin
        rdata_next = cur_pin;
      end else if (i_addr == `IOCN_ADDR_ENLO) begin
        rdata_next = en_lo_reg;
      end else if (i_addr == `IOCN_ADDR_ENHI) begin
        rdata_next = en_hi_reg;
      end else if (i_addr == `IOCN_ADDR_STAT) begin
        rdata_next = stat_reg;
      end else if (i_addr == `IOCN_ADDR_FLAG) begin
        rdata_next = flag_reg;
      end else if (i_addr == `IOCN_ADDR_MAP_AB) begin
        rdata_next = map_ab_reg;
      end else if (i_addr == `IOCN_ADDR_MAP_CD) begin
        rdata_next = map_cd_reg;
      end else if (i_addr == `IOCN_ADDR_LOCK) begin
        rdata_next[`IOCN_LOCK_BIT] = lock_reg;
      end else if (i_addr == `IOCN_ADDR_INMAP) begin
        rdata_next = inmap_reg;
      end else if (i_addr == `IOCN_ADDR_LAT) begin
        rdata_next = lat_reg;
      end
    end
  end

  // Read data stands one cycle after the strobe
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= `IOCN_RST_ZERO;
    end else begin
      o_rdata <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// ### dv/iocn_chk.sv
// Assertion checker for the pin change notifier and remapper
`timescale 1ns/10ps
`default_nettype none
`include "iocn_defines.vh"
module iocn_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [`IOCN_AW-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [`IOCN_DW-1:0] o_rdata,
  input wire logic [`IOCN_NFUNC-1:0] i_periph_out,
  input wire logic i_fixed_en,
  input wire logic i_fixed_out,
  input wire logic [`IOCN_NPINS-1:0] o_pin_out,
  input wire logic [`IOCN_NPINS-1:0] o_pin_oe,
  input wire logic [3:0] o_virt_pin,
  input wire logic o_cn_irq,
  input wire logic o_map_locked
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Helper terms
  wire lk_wr = i_wr && i_addr == `IOCN_ADDR_LOCK;
  wire all_out = o_pin_oe == 16'hffff && !i_fixed_en;
  // Steps of a settled lock with still sources
  sequence s_held_lock;
    o_map_locked [*3];
  endsequence
  sequence s_still_src;
    $stable(i_periph_out);
  endsequence
  // ******************************
  // Properties
  // ******************************
  chk_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_map_reserved_zero: assert property (i_rd && (i_addr == `IOCN_ADDR_MAP_AB || i_addr == `IOCN_ADDR_MAP_CD)
    |=> (o_rdata & 16'hc0c0) == 16'h0000) else $error("map reserved bits not zero");
  chk_unmapped_zero: assert property (i_rd && i_addr == 8'hfc |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_lock_change_cause: assert property ($changed(o_map_locked) |-> $past(lk_wr) || $past(lk_wr, 2))
    else $error("lock state changed without a lock write");
  chk_irq_flag_sticky: assert property (o_cn_irq && !i_wr && !$past(i_wr) |=> o_cn_irq)
    else $error("interrupt dropped without a write");
  chk_fixed_pin_owns: assert property (i_fixed_en |=> o_pin_oe[0] && o_pin_out[0] == $past(i_fixed_out))
    else $error("fixed peripheral not on its pin");
  chk_map_frozen_locked: assert property (s_held_lock ##0 s_still_src |=> $stable(o_virt_pin))
    else $error("mapping changed while locked");
  chk_output_no_irq: assert property (all_out [*3] |-> !$rose(o_cn_irq))
    else $error("interrupt raised with all pins as outputs");
endmodule
bind iocn_top iocn_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_periph_out(i_periph_out), .i_fixed_en(i_fixed_en),
  .i_fixed_out(i_fixed_out), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_virt_pin(o_virt_pin),
  .o_cn_irq(o_cn_irq), .o_map_locked(o_map_locked));
`default_nettype wire

// ### dv/iocn_far.sv
// Far side model: external pin drivers meeting the port's own drive
`timescale 1ns/10ps
`default_nettype none
module iocn_far #(parameter real DLY = 1.3) (
  input wire logic [15:0] i_ext,
  input wire logic [15:0] i_drv,
  input wire logic [15:0] i_oe,
  output logic [15:0] o_pin
);
  logic [15:0] ext_q = 16'h0000;
  // Outside level lands off the clock grid
  always @(i_ext) ext_q <= #(DLY) i_ext;
  // No pulls: a driven pin shows only the port's level
  assign o_pin = (i_oe & i_drv) | (~i_oe & ext_q);
endmodule
`default_nettype wire

// ### dv/test_io_change_notify_and_output_remap.sv
// Self-checking bench for the pin change notifier and remapper
`timescale 1ns/10ps
`default_nettype none
`include "iocn_defines.vh"
module test_io_change_notify_and_output_remap;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] ext = 16'h0000;
  logic [15:0] rdata, pin, pin_out, pin_oe;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic fx_en = 1'b0;
  logic fx_out = 1'b0;
  logic irq, locked;
  logic [63:0] pout = 64'h1;
  logic [1:0] pin_in;
  logic [3:0] virt;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  iocn_top u_dut (.i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pin(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_periph_out(pout),
    .i_fixed_en(fx_en), .i_fixed_out(fx_out), .o_periph_in(pin_in), .o_virt_pin(virt), .o_cn_irq(irq),
    .o_map_locked(locked));
  iocn_far #(.DLY(1.3)) u_far (.i_ext(ext), .i_drv(pin_out), .i_oe(pin_oe), .o_pin(pin));
  // ******************************
  // Clock, timeout, helpers
  // ******************************
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR %0t: run did not finish", $time);
      end_sim;
    end
  end
  task automatic end_sim;
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Expected event for one edge under a style and enable pair
  function automatic logic hit_exp(logic s, logic h, logic l, logic rise);
    if (!s) return l;
    return rise ? l : h;
  endfunction
  // Expected virtual ports; function zero leaves a port at 0
  function automatic logic [3:0] vexp(logic [15:0] ab, logic [15:0] cd);
    return {pout[cd[13:8]] && cd[13:8] != 0, pout[cd[5:0]] && cd[5:0] != 0,
      pout[ab[13:8]] && ab[13:8] != 0, pout[ab[5:0]] && ab[5:0] != 0};
  endfunction
  // One edge on pin 3, then interrupt check and flag, status and port reads
  task automatic edge_step(input logic lv, input logic e);
    rd_chk(`IOCN_ADDR_PORT, {12'h000, ~lv, 3'b000});
    tick(3);
    wr_reg(`IOCN_ADDR_FLAG, 16'hffff);
    tick(3);
    ext <= {12'h000, lv, 3'b000};
    tick(8);
    #1 chk({15'h0000, irq}, {15'h0000, e});
    rd_chk(`IOCN_ADDR_FLAG, {12'h000, e, 3'b000});
    rd_chk(`IOCN_ADDR_STAT, 16'h0008);
    rd_chk(`IOCN_ADDR_PORT, {12'h000, lv, 3'b000});
    rd_chk(`IOCN_ADDR_STAT, 16'h0000);
    chk({15'h0000, pin_in[0]}, {15'h0000, lv});
  endtask
  // ******************************
  // Main sequence
  // ******************************
  initial begin
    logic [15:0] v;
    logic s, h, l;
    void'($urandom(42));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`IOCN_ADDR_DIR, 16'hffff);
    rd_chk(`IOCN_ADDR_MAP_CD, 16'h0000);
    rd_chk(8'hfc, 16'h0000);
    chk({12'h000, virt}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'hc03f : 16'($urandom);
      @(posedge clk);
      pout <= {$urandom, $urandom} | 64'h1;
      wr_reg(`IOCN_ADDR_MAP_AB, v);
      wr_reg(`IOCN_ADDR_MAP_CD, ~v);
      rd_chk(`IOCN_ADDR_MAP_AB, v & 16'h3f3f);
      rd_chk(`IOCN_ADDR_MAP_CD, ~v & 16'h3f3f);
      chk({12'h000, virt}, {12'h000, vexp(v, ~v)});
    end
    wr_reg(`IOCN_ADDR_LOCK, 16'h0001);
    wr_reg(`IOCN_ADDR_MAP_AB, 16'h0101);
    rd_chk(`IOCN_ADDR_MAP_AB, v & 16'h3f3f);
    chk({15'h0000, locked}, 16'h0001);
    wr_reg(`IOCN_ADDR_LOCK, `IOCN_UNLOCK_KEY);
    wr_reg(`IOCN_ADDR_MAP_AB, 16'h0101);
    rd_chk(`IOCN_ADDR_MAP_AB, 16'h0101);
    // Input 0 from pin 3, input 1 from virtual port 3
    wr_reg(`IOCN_ADDR_INMAP, 16'h1404);
    tick(2);
    #1 chk({12'h000, pin_in[1], 3'b000}, {12'h000, vexp(16'h0101, ~v) & 4'h8});
    for (int k = 0; k < 8; k++) begin
      {s, h, l} = k[2:0];
      wr_reg(`IOCN_ADDR_CTRL, {1'b1, 3'b000, s, 11'h000});
      wr_reg(`IOCN_ADDR_ENLO, {12'h000, l, 3'b000});
      wr_reg(`IOCN_ADDR_ENHI, {12'h000, h, 3'b000});
      edge_step(1'b1, hit_exp(s, h, l, 1'b1));
      edge_step(1'b0, hit_exp(s, h, l, 1'b0));
    end
    // Output pins flag the edge but never interrupt
    wr_reg(`IOCN_ADDR_DIR, 16'h0000);
    wr_reg(`IOCN_ADDR_FLAG, 16'hffff);
    wr_reg(`IOCN_ADDR_LAT, 16'h0008);
    tick(8);
    chk({15'h0000, irq}, 16'h0000);
    chk(pin_out, 16'h0008);
    chk(pin_oe, 16'hffff);
    rd_chk(`IOCN_ADDR_FLAG, 16'h0008);
    // Port switched off: nothing is detected
    wr_reg(`IOCN_ADDR_CTRL, 16'h0000);
    wr_reg(`IOCN_ADDR_DIR, 16'hffff);
    wr_reg(`IOCN_ADDR_FLAG, 16'hffff);
    ext <= 16'h0008;
    tick(8);
    rd_chk(`IOCN_ADDR_FLAG, 16'h0000);
    @(posedge clk);
    fx_en <= 1'b1;
    fx_out <= 1'($urandom);
    tick(3);
    chk({14'h0000, pin_oe[0], pin_out[0]}, {14'h0000, 1'b1, fx_out});
    end_sim;
  end
endmodule
`default_nettype wire
